//--- shared/fmcps_pkg.sv
// constants for the flash mode control and power state block
`default_nettype none
package fmcps_pkg;
    // register offsets
    localparam logic [3:0] ADDR_MODE_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_EVT_STATUS = 4'h2;
    localparam logic [3:0] ADDR_EVT_MASK = 4'h3;
    localparam logic [3:0] ADDR_POWER = 4'h4;
    // mode control and status bit positions
    localparam int BIT_PROGRAM = 0;
    localparam int BIT_ERASE = 1;
    localparam int BIT_VERIFY = 2;
    localparam int BIT_PSETUP = 4;
    localparam int BIT_ESETUP = 5;
    localparam int BIT_SWE = 6;
    localparam int BIT_WEPIN = 7;
    localparam int BIT_ERROR = 7;
    // event bit positions
    localparam int EVT_ERROR = 0;
    localparam int EVT_WAKE = 1;
    localparam int EVT_W = 2;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [EVT_W-1:0] EVT_RESET = 2'h0;
    // chip operating states
    typedef enum logic [2:0] {
        FMCPS_ACTIVE = 3'h0,
        FMCPS_SLEEP = 3'h1,
        FMCPS_WATCH = 3'h2,
        FMCPS_STANDBY = 3'h3,
        FMCPS_MSTOP = 3'h4,
        FMCPS_SUBACT = 3'h5,
        FMCPS_SUBSLP = 3'h6
    } fmcps_chip_e;
    // flash array states, gray along normal -> power-down -> standby
    typedef enum logic [1:0] {
        FMCPS_NORMAL = 2'b00,
        FMCPS_PDOWN = 2'b01,
        FMCPS_STBY = 2'b11
    } fmcps_flash_e;
endpackage : fmcps_pkg
`default_nettype wire

//--- logic/fmcps_sync.sv
// two flop synchroniser for pin levels
`default_nettype none
module fmcps_sync (
    input wire logic clk_sys_in, // system clock
    input wire logic rst_b_in, // sync reset, active low
    input wire logic d_in, // asynchronous level
    output logic q_out // synchronised level
);
    logic meta_r;
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            meta_r <= 1'b0;
            q_out <= 1'b0;
        end else begin
            meta_r <= d_in;
            q_out <= meta_r;
        end
    end
endmodule : fmcps_sync
`default_nettype wire

//--- logic/fmcps_top.sv
// flash mode control, error protection and power state mapping
//
// Overview of operation
// (R1) verify bit gives verify mode under both enables
// (R2) verify bit sets only with both enables
// (R3) erase needs pin, software enable, erase setup
// (R4) program needs pin, software enable, program setup
// (R5) clearing a mode bit ends mode; reset zero
// (R6) fault sets error flag, enters error protection
// (R7) software never writes status; writes ignored
// (R8) status bits six to zero read zero
// (R9) normal state allows reads and writes
// (R10) standby state halts all flash access
// (R11) power-down state is read only
// (R12) chip modes map onto flash states
// (R13) software sets standby timer for wake wait; this block has no standby timer, the wake from standby is not delayed
// (R14) software waits after module stop exit
// (R15) error flag blocks program and erase entry
//
// Our own choices: the address map and strobed register access.
`default_nettype none
module fmcps_top (
    input wire logic clk_sys_in, // system clock 200 MHz
    input wire logic rst_b_in, // sync reset, active low
    input wire logic [3:0] addr_in, // register address
    input wire logic [7:0] wdata_in, // write data
    input wire logic wr_in, // write strobe
    input wire logic rd_in, // read strobe
    output logic [7:0] rdata_out, // read data, cycle after strobe
    input wire logic write_enable_pin_in, // flash write enable pin
    input wire logic fault_in, // program or erase fault pulse
    input wire logic [2:0] chip_state_in, // chip operating state
    output logic program_mode_out, // array in program mode
    output logic erase_mode_out, // array in erase mode
    output logic verify_mode_out, // array in program-verify mode
    output logic error_protect_out, // array in error protection
    output logic read_allow_out, // array readable
    output logic write_allow_out, // array writable
    output logic [1:0] flash_state_out, // flash power state
    output logic irq_out // interrupt, level
);
    import fmcps_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------
    logic wepin_s;
    fmcps_sync u_wepin (
        .clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in),
        .d_in(write_enable_pin_in),
        .q_out(wepin_s)
    );

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    wire wr_mode = wr_in && (addr_in == ADDR_MODE_CTRL);
    wire wr_mask = wr_in && (addr_in == ADDR_EVT_MASK);
    wire rd_evt = rd_in && (addr_in == ADDR_EVT_STATUS);

    logic [7:0] mode_r;
    logic [7:0] mode_nxt;
    logic error_r;
    logic [EVT_W-1:0] evt_r;
    logic [EVT_W-1:0] evt_nxt;
    logic [EVT_W-1:0] mask_r;
    fmcps_flash_e fstate_r;
    fmcps_flash_e fstate_nxt;

    // ------------------------------------------------------------
    // mode control register with setting interlocks
    // ------------------------------------------------------------
    wire swe_new = wdata_in[BIT_SWE];
    wire en_both = wepin_s && swe_new;
    wire not_err = !error_r;
    wire verify_ok = en_both; // R1 R2
    wire erase_ok = en_both && wdata_in[BIT_ESETUP] && not_err; // R3 R15
    wire prog_ok = en_both && wdata_in[BIT_PSETUP] && not_err; // R4 R15
    wire pin_drop = !wepin_s;

    always_comb begin
        mode_nxt = mode_r;
        if (wr_mode) begin
            mode_nxt = wdata_in;
            mode_nxt[BIT_WEPIN] = 1'b0;
            mode_nxt[BIT_VERIFY] = wdata_in[BIT_VERIFY] && verify_ok; // R2
            mode_nxt[BIT_ERASE] = wdata_in[BIT_ERASE] && erase_ok; // R3
            mode_nxt[BIT_PROGRAM] = wdata_in[BIT_PROGRAM] && prog_ok; // R4
        end
        // losing the pin or software enable ends every mode
        if (pin_drop || !mode_nxt[BIT_SWE]) begin
            mode_nxt[BIT_VERIFY] = 1'b0;
            mode_nxt[BIT_ERASE] = 1'b0;
            mode_nxt[BIT_PROGRAM] = 1'b0;
        end
        if (error_r) begin
            mode_nxt[BIT_ERASE] = 1'b0; // R15
            mode_nxt[BIT_PROGRAM] = 1'b0; // R15
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            mode_r <= MODE_RESET; // R5
        end else begin
            mode_r <= mode_nxt; // R5
        end
    end

    // ------------------------------------------------------------
    // error flag, cleared only by reset
    // ------------------------------------------------------------
    wire op_active = mode_r[BIT_PROGRAM] || mode_r[BIT_ERASE];
    wire fault_hit = fault_in && op_active;

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            error_r <= 1'b0;
        end else if (fault_hit) begin
            error_r <= 1'b1; // R6
        end
    end

    // ------------------------------------------------------------
    // chip to flash state mapping
    // ------------------------------------------------------------
    always_comb begin
        unique case (chip_state_in) // R12
            FMCPS_ACTIVE, FMCPS_SLEEP: fstate_nxt = FMCPS_NORMAL;
            FMCPS_WATCH, FMCPS_STANDBY, FMCPS_MSTOP: fstate_nxt = FMCPS_STBY;
            FMCPS_SUBACT, FMCPS_SUBSLP: fstate_nxt = FMCPS_PDOWN;
            default: fstate_nxt = FMCPS_STBY;
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            fstate_r <= FMCPS_NORMAL;
        end else begin
            fstate_r <= fstate_nxt;
        end
    end

    wire wake_evt = (fstate_r == FMCPS_STBY) && (fstate_nxt != FMCPS_STBY);
    wire rd_ok_nxt = (fstate_nxt != FMCPS_STBY); // R10 R11
    wire wr_ok_nxt = (fstate_nxt == FMCPS_NORMAL) && !error_r && !fault_hit; // R9 R11 R6

    // ------------------------------------------------------------
    // events and interrupt
    // ------------------------------------------------------------
    logic [EVT_W-1:0] evt_set;
    assign evt_set[EVT_ERROR] = fault_hit;
    assign evt_set[EVT_WAKE] = wake_evt;

    always_comb begin
        evt_nxt = rd_evt ? EVT_RESET : evt_r;
        evt_nxt = evt_nxt | evt_set; // set wins over read clear
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            evt_r <= EVT_RESET;
            mask_r <= EVT_RESET;
        end else begin
            evt_r <= evt_nxt;
            if (wr_mask) begin
                mask_r <= wdata_in[EVT_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // read mux; status register ignores writes
    // ------------------------------------------------------------
    logic [7:0] status_val;
    logic [7:0] mode_view;
    logic [7:0] rsel;
    always_comb begin
        status_val = STATUS_RESET; // R8
        status_val[BIT_ERROR] = error_r; // R7
        mode_view = mode_r;
        mode_view[BIT_WEPIN] = wepin_s;
        unique case (addr_in)
            ADDR_MODE_CTRL: rsel = mode_view;
            ADDR_STATUS: rsel = status_val;
            ADDR_EVT_STATUS: rsel = {{(8-EVT_W){1'b0}}, evt_r};
            ADDR_EVT_MASK: rsel = {{(8-EVT_W){1'b0}}, mask_r};
            ADDR_POWER: rsel = {6'h00, fstate_r};
            default: rsel = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            rdata_out <= 8'h00;
            program_mode_out <= 1'b0;
            erase_mode_out <= 1'b0;
            verify_mode_out <= 1'b0;
            error_protect_out <= 1'b0;
            read_allow_out <= 1'b0;
            write_allow_out <= 1'b0;
            flash_state_out <= FMCPS_NORMAL;
            irq_out <= 1'b0;
        end else begin
            rdata_out <= rd_in ? rsel : 8'h00;
            program_mode_out <= mode_nxt[BIT_PROGRAM]; // R4
            erase_mode_out <= mode_nxt[BIT_ERASE]; // R3
            verify_mode_out <= mode_nxt[BIT_VERIFY]; // R1
            error_protect_out <= error_r || fault_hit; // R6
            read_allow_out <= rd_ok_nxt;
            write_allow_out <= wr_ok_nxt;
            flash_state_out <= fstate_nxt;
            irq_out <= |(evt_nxt & mask_r);
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_verify_gate;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        verify_mode_out |-> $past(wepin_s) && mode_r[BIT_SWE];
    endproperty
    a_verify_gate: assert property (p_verify_gate) else $error("verify mode without enables"); // R1

    property p_verify_set;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (wr_mode && wdata_in[BIT_VERIFY] && !(wepin_s && wdata_in[BIT_SWE])) |=> !mode_r[BIT_VERIFY];
    endproperty
    a_verify_set: assert property (p_verify_set) else $error("verify bit set while disabled"); // R2

    property p_erase_set;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (wr_mode && wdata_in[BIT_ERASE] && wepin_s && wdata_in[BIT_SWE] && wdata_in[BIT_ESETUP] && !error_r)
        |=> erase_mode_out && mode_r[BIT_ERASE];
    endproperty
    a_erase_set: assert property (p_erase_set) else $error("erase entry refused"); // R3

    property p_prog_gate;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        $rose(mode_r[BIT_PROGRAM]) |-> mode_r[BIT_PSETUP] && mode_r[BIT_SWE];
    endproperty
    a_prog_gate: assert property (p_prog_gate) else $error("program entry without setup"); // R4

    property p_clear_ends;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (wr_mode && !wdata_in[BIT_ERASE]) |=> !erase_mode_out;
    endproperty
    a_clear_ends: assert property (p_clear_ends) else $error("erase mode not ended"); // R5

    sequence s_fault;
        fault_in && op_active;
    endsequence
    property p_error_set;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        s_fault |=> error_r && error_protect_out ##1 error_r[*2];
    endproperty
    a_error_set: assert property (p_error_set) else $error("error flag not held"); // R6

    property p_status_rsvd;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (rd_in && addr_in == ADDR_STATUS) |=> rdata_out[BIT_ERROR-1:0] == 7'h00;
    endproperty
    a_status_rsvd: assert property (p_status_rsvd) else $error("reserved status bits set"); // R8

    property p_standby;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (flash_state_out == FMCPS_STBY) |-> !read_allow_out && !write_allow_out;
    endproperty
    a_standby: assert property (p_standby) else $error("access in standby"); // R10

    property p_pdown;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (flash_state_out == FMCPS_PDOWN) |-> read_allow_out && !write_allow_out;
    endproperty
    a_pdown: assert property (p_pdown) else $error("power-down not read only"); // R11

    property p_map;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (chip_state_in == FMCPS_SUBACT) |=> flash_state_out == FMCPS_PDOWN;
    endproperty
    a_map: assert property (p_map) else $error("subactive not mapped"); // R12

    property p_normal;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (chip_state_in == FMCPS_ACTIVE && !error_r && !fault_hit) |=> read_allow_out && write_allow_out;
    endproperty
    a_normal: assert property (p_normal) else $error("normal state blocks access"); // R9

    property p_err_block;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        error_r |=> !program_mode_out && !erase_mode_out;
    endproperty
    a_err_block: assert property (p_err_block) else $error("mode entry under error"); // R15

    property p_prog_set;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (wr_mode && wdata_in[BIT_PROGRAM] && wepin_s && wdata_in[BIT_SWE] && wdata_in[BIT_PSETUP] && !error_r)
        |=> program_mode_out && mode_r[BIT_PROGRAM];
    endproperty
    a_prog_set: assert property (p_prog_set) else $error("program entry refused"); // R4

    property p_verify_enter;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (wr_mode && wdata_in[BIT_VERIFY] && wepin_s && wdata_in[BIT_SWE]) |=> verify_mode_out;
    endproperty
    a_verify_enter: assert property (p_verify_enter) else $error("verify entry refused"); // R1

    property p_clear_prog;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (wr_mode && !wdata_in[BIT_PROGRAM]) |=> !program_mode_out;
    endproperty
    a_clear_prog: assert property (p_clear_prog) else $error("program mode not ended"); // R5

    property p_clear_verify;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (wr_mode && !wdata_in[BIT_VERIFY]) |=> !verify_mode_out;
    endproperty
    a_clear_verify: assert property (p_clear_verify) else $error("verify mode not ended"); // R5

    property p_status_keep;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (wr_in && addr_in == ADDR_STATUS && !fault_hit) |=> error_r == $past(error_r);
    endproperty
    a_status_keep: assert property (p_status_keep) else $error("status changed by write"); // R7

    property p_wr_block;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        error_r |=> !write_allow_out;
    endproperty
    a_wr_block: assert property (p_wr_block) else $error("write allowed under error"); // R6

    property p_map_sub;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (chip_state_in == FMCPS_SUBSLP) |=> flash_state_out == FMCPS_PDOWN;
    endproperty
    a_map_sub: assert property (p_map_sub) else $error("subsleep not mapped"); // R12

    property p_map_stby;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (chip_state_in == FMCPS_WATCH || chip_state_in == FMCPS_STANDBY || chip_state_in == FMCPS_MSTOP)
        |=> flash_state_out == FMCPS_STBY;
    endproperty
    a_map_stby: assert property (p_map_stby) else $error("standby modes not mapped"); // R12
endmodule : fmcps_top
`default_nettype wire

//--- testbench/test_fmcps_top.sv
// self-checking bench for the flash mode control and power state block
`default_nettype none
module test_fmcps_top;
    timeunit 1ns;
    timeprecision 100ps;
    import fmcps_pkg::*;
    // ----------------------------------------
    // signals and instance
    // ----------------------------------------
    logic clk_sys_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [3:0] addr_in = 4'h0;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic pin_in = 1'b0;
    logic fault_in = 1'b0;
    logic [2:0] chip_in = 3'h0;
    logic [7:0] rdata_out;
    logic prog_out, erase_out, verify_out, prot_out, rdok_out, wrok_out, irq_out;
    logic [1:0] fstate_out;
    int err_total = 0;
    int check_count = 0;
    int cycles = 0;
    logic [7:0] rv;
    logic [1:0] es;
    fmcps_top DUT (
        .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .write_enable_pin_in(pin_in),
        .fault_in(fault_in), .chip_state_in(chip_in), .program_mode_out(prog_out),
        .erase_mode_out(erase_out), .verify_mode_out(verify_out), .error_protect_out(prot_out),
        .read_allow_out(rdok_out), .write_allow_out(wrok_out), .flash_state_out(fstate_out),
        .irq_out(irq_out)
    );
    initial begin
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end
    // ----------------------------------------
    // timeout
    // ----------------------------------------
    always @(posedge clk_sys_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total = err_total + 1;
            tally_and_finish();
        end
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic check8(input logic [7:0] act, input logic [7:0] exp);
        check_count = check_count + 1;
        if (act !== exp) begin
            err_total = err_total + 1;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, act, exp);
        end
    endtask : check8
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
        #1;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_sys_in);
        rd_in <= 1'b0;
        #1;
        d = rdata_out;
    endtask : rd_reg
    task automatic modes(input logic [2:0] exp);
        check8({5'h0, verify_out, erase_out, prog_out}, {5'h0, exp});
    endtask : modes
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask : wait_cyc
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        wait_cyc(3);
        modes(3'b000);
        check8({7'h0, prot_out}, 8'h00);
        rd_reg(ADDR_MODE_CTRL, rv);
        check8(rv, MODE_RESET);
        rd_reg(ADDR_STATUS, rv);
        check8(rv, STATUS_RESET);
        rd_reg(4'hf, rv);
        check8(rv, 8'h00);
        $display("test reset done");
        wr_reg(ADDR_MODE_CTRL, 8'h77);
        modes(3'b000);
        rd_reg(ADDR_MODE_CTRL, rv);
        check8(rv, 8'h70);
        $display("test pin low done");
        @(posedge clk_sys_in) pin_in <= 1'b1;
        wait_cyc(3);
        wr_reg(ADDR_MODE_CTRL, 8'h44);
        modes(3'b100);
        wr_reg(ADDR_MODE_CTRL, 8'h40);
        modes(3'b000);
        wr_reg(ADDR_MODE_CTRL, 8'h42);
        modes(3'b000);
        wr_reg(ADDR_MODE_CTRL, 8'h62);
        modes(3'b010);
        wr_reg(ADDR_MODE_CTRL, 8'h60);
        modes(3'b000);
        wr_reg(ADDR_MODE_CTRL, 8'h41);
        modes(3'b000);
        wr_reg(ADDR_MODE_CTRL, 8'h51);
        modes(3'b001);
        wr_reg(ADDR_MODE_CTRL, 8'h10);
        modes(3'b000);
        wr_reg(ADDR_MODE_CTRL, 8'h62);
        @(posedge clk_sys_in) pin_in <= 1'b0;
        wait_cyc(4);
        modes(3'b000);
        @(posedge clk_sys_in) pin_in <= 1'b1;
        wait_cyc(3);
        $display("test interlocks done");
        wr_reg(ADDR_STATUS, 8'hff);
        rd_reg(ADDR_STATUS, rv);
        check8(rv, 8'h00);
        $display("test status write done");
        wr_reg(ADDR_EVT_MASK, 8'h03);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys_in) chip_in <= i[2:0];
            wait_cyc(3);
            es = (i == 0 || i == 1) ? FMCPS_NORMAL : (i == 5 || i == 6) ? FMCPS_PDOWN : FMCPS_STBY;
            check8({6'h0, fstate_out}, {6'h0, es});
            check8({7'h0, rdok_out}, {7'h0, es != FMCPS_STBY});
            check8({7'h0, wrok_out}, {7'h0, es == FMCPS_NORMAL});
            rd_reg(ADDR_POWER, rv);
            check8(rv, {6'h0, es});
        end
        @(posedge clk_sys_in) chip_in <= 3'h0;
        wait_cyc(3);
        rd_reg(ADDR_EVT_STATUS, rv);
        rd_reg(ADDR_EVT_STATUS, rv);
        check8(rv, 8'h00);
        @(posedge clk_sys_in) chip_in <= 3'h3;
        wait_cyc(3);
        check8({7'h0, irq_out}, 8'h00);
        @(posedge clk_sys_in) chip_in <= 3'h0;
        wait_cyc(3);
        check8({7'h0, irq_out}, 8'h01);
        rd_reg(ADDR_EVT_STATUS, rv);
        check8(rv, 8'h02);
        wait_cyc(1);
        check8({7'h0, irq_out}, 8'h00);
        $display("test power states done");
        wr_reg(ADDR_EVT_MASK, 8'h00);
        wr_reg(ADDR_MODE_CTRL, 8'h51);
        modes(3'b001);
        @(posedge clk_sys_in);
        fault_in <= 1'b1;
        @(posedge clk_sys_in);
        fault_in <= 1'b0;
        wait_cyc(2);
        check8({7'h0, prot_out}, 8'h01);
        check8({7'h0, wrok_out}, 8'h00);
        check8({7'h0, irq_out}, 8'h00);
        rd_reg(ADDR_STATUS, rv);
        check8(rv, 8'h80);
        wr_reg(ADDR_EVT_MASK, 8'h01);
        wait_cyc(1);
        check8({7'h0, irq_out}, 8'h01);
        rd_reg(ADDR_EVT_STATUS, rv);
        check8(rv, 8'h01);
        wait_cyc(1);
        check8({7'h0, irq_out}, 8'h00);
        wr_reg(ADDR_MODE_CTRL, 8'h51);
        modes(3'b000);
        wr_reg(ADDR_MODE_CTRL, 8'h62);
        modes(3'b000);
        wr_reg(ADDR_STATUS, 8'h00);
        rd_reg(ADDR_STATUS, rv);
        check8(rv, 8'h80);
        $display("test error protection done");
        @(posedge clk_sys_in);
        rst_b_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        wait_cyc(3);
        check8({7'h0, prot_out}, 8'h00);
        wr_reg(ADDR_MODE_CTRL, 8'h51);
        modes(3'b001);
        $display("test reset after error done");
        tally_and_finish();
    end
endmodule : test_fmcps_top
`default_nettype wire
